// ---- rtl/aipc_pkg.sv ----
package aipc_pkg;

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [11:0] ADDR_INPUT_CLOCK = 12'h000;
	localparam logic [11:0] ADDR_AMP_REF = 12'h004;
	localparam logic [11:0] ADDR_BANDGAP = 12'h008;
	localparam logic [11:0] ADDR_EXT_CHANNEL = 12'h00c;

	// ------------------------------------------------------------
	// Reset values and writable masks
	// ------------------------------------------------------------
	localparam logic [7:0] RESET_VALUE = 8'h00;
	localparam logic [7:0] MASK_INPUT_CLOCK = 8'hf7;
	localparam logic [7:0] MASK_AMP_REF = 8'h9f;
	localparam logic [7:0] MASK_BANDGAP = 8'h01;
	localparam logic [7:0] MASK_EXT_CHANNEL = 8'h0f;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int SRC_LSB = 4;
	localparam int CLKDIV_LSB = 0;
	localparam int AMP_EN_BIT = 7;
	localparam int AMP_IN_BIT = 4;
	localparam int REF_LSB = 2;
	localparam int GAIN_LSB = 0;
	localparam int BG_EN_BIT = 0;

	// ------------------------------------------------------------
	// Input source one-hot positions
	// ------------------------------------------------------------
	localparam int SRC_EXTERNAL = 0;
	localparam int SRC_SUPPLY = 1;
	localparam int SRC_SUPPLY_HALF = 2;
	localparam int SRC_SUPPLY_QUARTER = 3;
	localparam int SRC_AMP = 4;
	localparam int SRC_AMP_HALF = 5;
	localparam int SRC_AMP_QUARTER = 6;
	localparam int SRC_GROUND = 7;
	localparam int SRC_COUNT = 8;

	// ------------------------------------------------------------
	// Reference one-hot positions
	// ------------------------------------------------------------
	localparam int REF_SUPPLY = 0;
	localparam int REF_PIN = 1;
	localparam int REF_AMP = 2;
	localparam int REF_COUNT = 3;

	// Highest divider code; divisor is 2 to this power
	localparam logic [2:0] CLKDIV_MAX = 3'h7;
	localparam int CLKDIV_WIDTH = 7;

endpackage : aipc_pkg

// ---- rtl/aipc_clock_divider.sv ----
`timescale 1ns/100ps
`default_nettype none

module aipc_clock_divider #(
	parameter int WIDTH = aipc_pkg::CLKDIV_WIDTH
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [2:0] div_sel,
	output logic conv_clk_en
);

	// Narrower counters cannot reach division by 128
	if (WIDTH < 7) begin : g_width_check
		$error("aipc_clock_divider: WIDTH must cover division by 128");
	end

	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] limit;

	// Terminal count is divisor minus one
	assign limit = WIDTH'((1 << div_sel) - 1);

	// ------------------------------------------------------------
	// Free-running counter, restarts on terminal count
	// ------------------------------------------------------------
	// Count above the new limit after a shrink falls back at once
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_reg <= '0;
		end else if (count_reg >= limit) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_reg + 1'b1;
		end
	end

	// Enable pulse one hclk wide; code 000 gives it every cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			conv_clk_en <= 1'b0;
		end else begin
			conv_clk_en <= (count_reg >= limit);
		end
	end

endmodule : aipc_clock_divider

`default_nettype wire

// ---- rtl/aipc_config.sv ----
// Function
// - Source codes pick external, supply, amplifier or ground
// - Internal source forces external channel path off
// - Conversion clock divides system clock by power two
// - Amplifier enable bit turns amplifier on
// - Input select routes pin or bandgap to amplifier
// - Bandgap input disconnects reference input pin
// - Reference field picks supply, pin or amplifier
// - Internal reference disconnects external reference pin
// - Gain field selects one of four gains
// - Bandgap enable bit turns bandgap circuit on
// - Unimplemented bits always read as zero
// - External channel field picks converted input pin
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module aipc_config (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic [7:0] input_source_onehot,
	output logic [15:0] external_channel_onehot,
	output logic [2:0] conv_clock_div_sel,
	output logic conv_clk_en,
	output logic amplifier_enable,
	output logic amp_from_ref_pin,
	output logic amp_from_bandgap,
	output logic [1:0] amplifier_gain_sel,
	output logic [2:0] converter_ref_onehot,
	output logic bandgap_enable
);

	// ------------------------------------------------------------
	// Stored registers
	// ------------------------------------------------------------
	logic [7:0] input_clock_reg;
	logic [7:0] amp_ref_reg;
	logic [7:0] bandgap_reg;
	logic [7:0] ext_channel_reg;

	// ------------------------------------------------------------
	// Bus capture of the address phase
	// ------------------------------------------------------------
	logic wr_pend_reg;
	logic [11:0] wr_addr_reg;
	logic rd_go;
	logic [31:0] rd_value;

	logic [3:0] input_source_sel;
	logic [3:0] external_channel_sel;
	logic [1:0] converter_ref_sel;
	logic external_path_on;
	logic [7:0] src_next;
	logic [2:0] ref_next;
	logic div_pulse;
	logic [7:0] input_clock_next;
	logic [7:0] amp_ref_next;
	logic [7:0] bandgap_next;
	logic [7:0] ext_channel_next;

	// Decodes read the next value so controls switch on the write edge
	assign input_source_sel = input_clock_next[aipc_pkg::SRC_LSB +: 4];
	assign external_channel_sel = ext_channel_next[3:0];
	assign converter_ref_sel = amp_ref_next[aipc_pkg::REF_LSB +: 2];

	// Writes are taken one cycle later, in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 12'h000;
		end else if (hready) begin
			wr_pend_reg <= hsel && htrans[1] && hwrite && (hsize == 3'h2);
			wr_addr_reg <= haddr;
		end
	end

	// Zero wait states; response always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	// Masks drop writes to unimplemented bits so they stay zero
	always_comb begin
		input_clock_next = input_clock_reg;
		amp_ref_next = amp_ref_reg;
		bandgap_next = bandgap_reg;
		ext_channel_next = ext_channel_reg;
		if (wr_pend_reg) begin
			case (wr_addr_reg)
				aipc_pkg::ADDR_INPUT_CLOCK: begin
					input_clock_next = hwdata[7:0] & aipc_pkg::MASK_INPUT_CLOCK;
				end
				aipc_pkg::ADDR_AMP_REF: begin
					amp_ref_next = hwdata[7:0] & aipc_pkg::MASK_AMP_REF;
				end
				aipc_pkg::ADDR_BANDGAP: begin
					bandgap_next = hwdata[7:0] & aipc_pkg::MASK_BANDGAP;
				end
				aipc_pkg::ADDR_EXT_CHANNEL: begin
					ext_channel_next = hwdata[7:0] & aipc_pkg::MASK_EXT_CHANNEL;
				end
				default: begin
				end
			endcase
		end
	end

	// Stored registers take their next value on every edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			input_clock_reg <= aipc_pkg::RESET_VALUE;
			amp_ref_reg <= aipc_pkg::RESET_VALUE;
			bandgap_reg <= aipc_pkg::RESET_VALUE;
			ext_channel_reg <= aipc_pkg::RESET_VALUE;
		end else begin
			input_clock_reg <= input_clock_next;
			amp_ref_reg <= amp_ref_next;
			bandgap_reg <= bandgap_next;
			ext_channel_reg <= ext_channel_next;
		end
	end

	// ------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------
	assign rd_go = hready && hsel && htrans[1] && !hwrite;

	// Unmapped addresses read zero; upper bits always zero
	// Next values let a read right behind a write see the new data
	always_comb begin
		rd_value = 32'h0000_0000;
		case (haddr)
			aipc_pkg::ADDR_INPUT_CLOCK: rd_value = {24'h000000, input_clock_next};
			aipc_pkg::ADDR_AMP_REF: rd_value = {24'h000000, amp_ref_next};
			aipc_pkg::ADDR_BANDGAP: rd_value = {24'h000000, bandgap_next};
			aipc_pkg::ADDR_EXT_CHANNEL: rd_value = {24'h000000, ext_channel_next};
			default: rd_value = 32'h0000_0000;
		endcase
	end

	// Read data registered so it stands through the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_go) begin
			hrdata <= rd_value;
		end
	end

	// ------------------------------------------------------------
	// Input source decode
	// ------------------------------------------------------------
	always_comb begin
		src_next = 8'h00;
		case (input_source_sel)
			4'h1: src_next[aipc_pkg::SRC_SUPPLY] = 1'b1;
			4'h2: src_next[aipc_pkg::SRC_SUPPLY_HALF] = 1'b1;
			4'h3: src_next[aipc_pkg::SRC_SUPPLY_QUARTER] = 1'b1;
			4'h5: src_next[aipc_pkg::SRC_AMP] = 1'b1;
			4'h6: src_next[aipc_pkg::SRC_AMP_HALF] = 1'b1;
			4'h7: src_next[aipc_pkg::SRC_AMP_QUARTER] = 1'b1;
			4'h8, 4'h9, 4'ha, 4'hb: src_next[aipc_pkg::SRC_GROUND] = 1'b1;
			default: src_next[aipc_pkg::SRC_EXTERNAL] = 1'b1;
		endcase
	end

	// Any internal pick isolates the external pins from the mux
	assign external_path_on = src_next[aipc_pkg::SRC_EXTERNAL];

	// ------------------------------------------------------------
	// Reference decode
	// ------------------------------------------------------------
	always_comb begin
		ref_next = 3'h0;
		case (converter_ref_sel)
			2'h0: ref_next[aipc_pkg::REF_SUPPLY] = 1'b1;
			2'h1: ref_next[aipc_pkg::REF_PIN] = 1'b1;
			default: ref_next[aipc_pkg::REF_AMP] = 1'b1;
		endcase
	end

	// ------------------------------------------------------------
	// Analog control outputs
	// ------------------------------------------------------------
	// Flops decode the next value, so switch controls change on the
	// write edge and still come glitch-free from a register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			input_source_onehot <= 8'h01;
			external_channel_onehot <= 16'h0001;
		end else begin
			input_source_onehot <= src_next;
			external_channel_onehot <= external_path_on ?
				(16'h0001 << external_channel_sel) : 16'h0000;
		end
	end

	// Amplifier, gain and reference switch controls
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			amplifier_enable <= 1'b0;
			amp_from_ref_pin <= 1'b1;
			amp_from_bandgap <= 1'b0;
			amplifier_gain_sel <= 2'h0;
			converter_ref_onehot <= 3'h1;
		end else begin
			amplifier_enable <= amp_ref_next[aipc_pkg::AMP_EN_BIT];
			amp_from_ref_pin <= !amp_ref_next[aipc_pkg::AMP_IN_BIT];
			amp_from_bandgap <= amp_ref_next[aipc_pkg::AMP_IN_BIT];
			amplifier_gain_sel <= amp_ref_next[aipc_pkg::GAIN_LSB +: 2];
			converter_ref_onehot <= ref_next;
		end
	end

	// Bandgap is not interlocked with the amplifier input; software
	// must enable it and wait for settling first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bandgap_enable <= 1'b0;
			conv_clock_div_sel <= 3'h0;
			conv_clk_en <= 1'b0;
		end else begin
			bandgap_enable <= bandgap_next[aipc_pkg::BG_EN_BIT];
			conv_clock_div_sel <= input_clock_next[aipc_pkg::CLKDIV_LSB +: 3];
			conv_clk_en <= div_pulse;
		end
	end

	// ------------------------------------------------------------
	// Conversion clock divider
	// ------------------------------------------------------------
	aipc_clock_divider #(
		.WIDTH(aipc_pkg::CLKDIV_WIDTH)
	) u_divider (
		.hclk(hclk),
		.hresetn(hresetn),
		.div_sel(input_clock_reg[aipc_pkg::CLKDIV_LSB +: 3]),
		.conv_clk_en(div_pulse)
	);

endmodule : aipc_config

`default_nettype wire

// ---- test/aipc_config_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module aipc_config_asserts (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic [7:0] input_source_onehot,
	input wire logic [15:0] external_channel_onehot,
	input wire logic [2:0] conv_clock_div_sel,
	input wire logic conv_clk_en,
	input wire logic amp_from_ref_pin,
	input wire logic amp_from_bandgap,
	input wire logic [2:0] converter_ref_onehot,
	input wire logic bandgap_enable
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic rd_q;
	// Marks the data phase of a read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_q <= 1'b0;
		end else begin
			rd_q <= hsel && hready && htrans[1] && !hwrite;
		end
	end
	chk_src_onehot: assert property ($onehot(input_source_onehot))
		else $error("source select not one-hot");
	chk_ext_off: assert property (
		!input_source_onehot[0] |-> external_channel_onehot == 16'h0000)
		else $error("external path on with internal source");
	chk_ext_chan: assert property (
		input_source_onehot[0] |-> $onehot(external_channel_onehot))
		else $error("no single external channel");
	chk_amp_switch: assert property (amp_from_ref_pin != amp_from_bandgap)
		else $error("amplifier input switches clash");
	chk_ref_onehot: assert property ($onehot(converter_ref_onehot))
		else $error("reference select not one-hot");
	// Double pulses would mean the divider ignores a nonzero code
	chk_div_pulse: assert property (
		(conv_clock_div_sel != 3'h0 && $stable(conv_clock_div_sel))[*3] ##0 conv_clk_en
		|=> !conv_clk_en)
		else $error("divided clock pulses twice in a row");
	chk_upper_zero: assert property (rd_q |-> hrdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	// Control follows on the data-phase edge of the write
	chk_bg_latency: assert property (
		(hsel && hready && htrans[1] && hwrite && hsize == 3'h2
		&& haddr == aipc_pkg::ADDR_BANDGAP) ##1 1'b1
		|=> bandgap_enable == $past(hwdata[0]))
		else $error("bandgap enable late or wrong");
endmodule // aipc_config_asserts
bind aipc_config aipc_config_asserts i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hsize, .hwdata, .hready, .hrdata, .input_source_onehot, .external_channel_onehot,
	.conv_clock_div_sel, .conv_clk_en, .amp_from_ref_pin, .amp_from_bandgap,
	.converter_ref_onehot, .bandgap_enable);
`default_nettype wire

// ---- test/tb_adc_input_ref_pga_config.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin errors++; \
	$display("CHECK FAILED t=%0t %s", $time, m); end end
module tb_adc_input_ref_pga_config;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata, rdat;
	logic hreadyout, hresp, conv_clk_en, amplifier_enable, amp_from_ref_pin, amp_from_bandgap;
	logic bandgap_enable;
	logic [7:0] input_source_onehot;
	logic [15:0] external_channel_onehot;
	logic [2:0] conv_clock_div_sel, converter_ref_onehot;
	logic [1:0] amplifier_gain_sel;
	int errors = 0;
	int samples_checked = 0;
	// Single slave, so its ready is the bus ready
	aipc_config i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .input_source_onehot,
		.external_channel_onehot, .conv_clock_div_sel, .conv_clk_en, .amplifier_enable,
		.amp_from_ref_pin, .amp_from_bandgap, .amplifier_gain_sel, .converter_ref_onehot,
		.bandgap_enable);
	always #5 hclk = ~hclk;
	// Expected one-hot source position for each code
	function automatic logic [7:0] src_exp(input logic [3:0] c);
		if (c[3]) begin
			return c[2] ? 8'h01 : 8'h80;
		end
		return 8'h01 << (c[1:0] + (c[2] && c[1:0] != 2'h0 ? 3 : 0));
	endfunction
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Bounded so a stuck ready cannot hang the run
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (n >= 64) begin
			errors++;
			end_of_test();
		end
	endtask
	task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		wait_ready();
		rdat = hrdata;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		bus(a, 1'b0, 8'h00);
		`CHK(rdat, e, "register read")
		`CHK(hresp, 1'b0, "bus response")
	endtask
	task automatic t_reset();
		`CHK(input_source_onehot, 8'h01, "source reset")
		`CHK(external_channel_onehot, 16'h0001, "channel reset")
		`CHK({amplifier_enable, amp_from_ref_pin, amp_from_bandgap}, 3'h2, "amp reset")
		`CHK(bandgap_enable, 1'b0, "bandgap reset")
		`CHK(converter_ref_onehot, 3'h1, "ref reset")
		for (int i = 0; i < 5; i++) rdc(12'(4 * i), 32'h0);
		$display("reset test done");
	endtask
	// Bit 3 is written high every time but must read back low
	task automatic t_source();
		logic [7:0] e;
		bus(aipc_pkg::ADDR_EXT_CHANNEL, 1'b1, 8'h05);
		for (int c = 0; c < 16; c++) begin
			e = src_exp(4'(c));
			bus(aipc_pkg::ADDR_INPUT_CLOCK, 1'b1, 8'(c * 16 + 8));
			rdc(aipc_pkg::ADDR_INPUT_CLOCK, {24'h0, 4'(c), 4'h0});
			`CHK(input_source_onehot, e, "source")
			`CHK(external_channel_onehot, e[0] ? 16'h0020 : 16'h0, "channel")
		end
		$display("source test done");
	endtask
	task automatic t_clkdiv();
		int n;
		for (int c = 0; c < 8; c++) begin
			bus(aipc_pkg::ADDR_INPUT_CLOCK, 1'b1, 8'(c));
			repeat (256) @(posedge hclk);
			n = 0;
			repeat (256) begin
				@(posedge hclk);
				n += int'(conv_clk_en);
			end
			`CHK(conv_clock_div_sel, 3'(c), "divider code")
			`CHK(n, 256 >> c, "divider pulses")
		end
		$display("divider test done");
	endtask
	task automatic t_ampref();
		logic [7:0] b;
		bus(aipc_pkg::ADDR_BANDGAP, 1'b1, 8'h01);
		// Settling time is not known here; give the bandgap a margin first
		repeat (64) @(posedge hclk);
		for (int v = 0; v < 256; v++) begin
			b = 8'(v);
			// No pin sharing in this bench; reference-pin codes assume it freed
			bus(aipc_pkg::ADDR_AMP_REF, 1'b1, b);
			rdc(aipc_pkg::ADDR_AMP_REF, {24'h0, b & 8'h9f});
			`CHK({amplifier_enable, amplifier_gain_sel}, {b[7], b[1:0]}, "amp")
			`CHK({amp_from_bandgap, amp_from_ref_pin}, {b[4], !b[4]}, "amp in")
			`CHK(converter_ref_onehot, b[3] ? 3'h4 : (b[2] ? 3'h2 : 3'h1), "ref")
		end
		$display("amplifier test done");
	endtask
	task automatic t_bandgap();
		for (int i = 0; i < 2; i++) begin
			bus(aipc_pkg::ADDR_BANDGAP, 1'b1, 8'hfe | 8'(i));
			rdc(aipc_pkg::ADDR_BANDGAP, 32'(i));
			`CHK(bandgap_enable, 1'(i), "bandgap")
		end
		$display("bandgap test done");
	endtask
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_source();
		t_clkdiv();
		t_ampref();
		t_bandgap();
		end_of_test();
	end
endmodule // tb_adc_input_ref_pga_config
`default_nettype wire
